// >>> icx_pkg.sv
// Overview of operation
// - Accepting an interrupt clears global enable
// - Return instruction sets global enable again
// - Vectoring clears the causing flag in hardware
// - Writing one clears a flag, zero keeps
// - Flag sets even while its enable is off
// - Pending flags served by priority once enabled
// - Level request has no latched flag
// - Status register never saved or restored here
// - Entry takes four cycles, pushes 13-bit counter
// - Multicycle instruction finishes before entry starts
// - Sleep adds four cycles to entry
// - Return takes four cycles, pops two bytes
// - One instruction runs after return before next
// - Request 1 enable bit 7, vector 004
// - Request 0 enable bit 6, vector 002
// - Pin activity requests even when pin drives
// - Mask bits 5..0 read zero
// - Request 1 edge sets flag bit 7
// - Request 0 event sets flag bit 6
// - Flag reads cleared while level sensing
// - Flag register bits 5..0 read zero
// - Level request persists while pin held low
// - Sense bits: 3..2 request 1, 1..0 request 0
`default_nettype none

package icx_pkg;

   // ==========================================================
   // Register map
   localparam int          ICX_AW        = 2;
   localparam logic [1:0]  OFS_MASK      = 2'h0;
   localparam logic [1:0]  OFS_FLAG      = 2'h1;
   localparam logic [1:0]  OFS_CTRL      = 2'h2;
   localparam logic [1:0]  OFS_STAT      = 2'h3;
   localparam int          BIT_EN1       = 7;
   localparam int          BIT_EN0       = 6;
   localparam int          BIT_FLAG1     = 7;
   localparam int          BIT_FLAG0     = 6;
   localparam int          BIT_S1_HI     = 3;
   localparam int          BIT_S1_LO     = 2;
   localparam int          BIT_S0_HI     = 1;
   localparam int          BIT_S0_LO     = 0;
   localparam int          BIT_GIE       = 7;

   // ==========================================================
   // Sense codes and vectors
   localparam logic [1:0]  SENSE_LEVEL   = 2'h0;
   localparam logic [1:0]  SENSE_ANY     = 2'h1;
   localparam logic [1:0]  SENSE_FALL    = 2'h2;
   localparam logic [1:0]  SENSE_RISE    = 2'h3;
   localparam int          PC_W          = 13;
   localparam logic [12:0] VEC_EXT0      = 13'h002;
   localparam logic [12:0] VEC_EXT1      = 13'h004;

   // ==========================================================
   // Timing counts in clock cycles, reset values
   localparam logic [3:0]  ENTRY_CYC     = 4'h4;
   localparam logic [3:0]  SLEEP_EXTRA   = 4'h4;
   localparam logic [3:0]  RET_CYC       = 4'h4;
   localparam logic [1:0]  SENSE_RST     = 2'h0;
   localparam logic        GIE_RST       = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ENTRY  = 2'b01,
      ST_RETURN = 2'b10
   } icx_fsm_t;

   // Stack request to the core
   typedef struct packed {
      logic       push;
      logic       pop;
      logic       sp_add2;
      logic [7:0] data;
   } icx_stack_t;

   typedef struct packed {
      icx_fsm_t          fsm;
      logic [3:0]        step;
      logic [3:0]        last;
      logic              gie;
      logic              en1;
      logic              en0;
      logic              flag1;
      logic              flag0;
      logic [1:0]        sense1;
      logic [1:0]        sense0;
      logic [1:0]        sync1;
      logic [1:0]        sync0;
      logic              prev1;
      logic              prev0;
      logic              src1;
      logic [PC_W-1:0]   pc;
      icx_stack_t        stk;
      logic              ebusy;
      logic              rbusy;
      logic              vec_valid;
      logic [PC_W-1:0]   vector;
      logic              ret_done;
      logic [7:0]        rdata;
   } icx_state_t;

endpackage : icx_pkg

`default_nettype wire

// >>> icx_ctrl.sv
`default_nettype none

module icx_ctrl
   import icx_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   // Register port
   input  wire logic [ICX_AW-1:0] addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              we_in,
   input  wire logic              re_in,
   output logic      [7:0]        rdata_out,
   // Processor core
   input  wire logic              instr_done_in,
   input  wire logic              sleep_in,
   input  wire logic              return_from_irq_instr_in,
   input  wire logic [PC_W-1:0]   pc_in,
   output logic                   gie_out,
   output logic                   entry_busy_out,
   output logic                   ret_busy_out,
   output logic                   vec_valid_out,
   output logic      [PC_W-1:0]   vector_out,
   output logic                   ret_done_out,
   output icx_stack_t             stack_out,
   // External request pins
   input  wire logic              ext0_pin_in,
   input  wire logic              ext1_pin_in
);

   // ==========================================================
   // State
   icx_state_t r;
   icx_state_t n;

   logic lvl0;
   logic lvl1;
   logic set0;
   logic set1;
   logic req0;
   logic req1;
   logic pend0;
   logic pend1;
   logic hwclr0;
   logic hwclr1;
   logic accept;
   logic ret_go;
   logic wr_flag;

   // Edge test on synchronised pin samples
   function automatic logic edge_hit(input logic [1:0] sense,
                                     input logic       cur,
                                     input logic       prev);
      logic hit;
      hit = 1'b0;
      case (sense)
         SENSE_ANY:  hit = cur ^ prev;
         SENSE_FALL: hit = prev & ~cur;
         SENSE_RISE: hit = ~prev & cur;
         default:    hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_hit

   // ==========================================================
   // Request decode
   // Pins are sampled regardless of port direction, so a driven pin
   // still requests; this is the software trigger path.
   always_comb
   begin
      lvl0    = (r.sense0 == SENSE_LEVEL);
      lvl1    = (r.sense1 == SENSE_LEVEL);
      set0    = ~lvl0 & edge_hit(r.sense0, r.sync0[1], r.prev0);
      set1    = ~lvl1 & edge_hit(r.sense1, r.sync1[1], r.prev1);
      // Level request lives only while pin is low, never latched
      req0    = lvl0 ? ~r.sync0[1] : r.flag0;
      req1    = lvl1 ? ~r.sync1[1] : r.flag1;
      pend0   = r.en0 & req0;
      pend1   = r.en1 & req1;
      // Boundary only: core reports the end of a whole instruction
      accept  = (r.fsm == ST_IDLE) & r.gie & instr_done_in & ~return_from_irq_instr_in
                & (pend0 | pend1);
      ret_go  = (r.fsm == ST_IDLE) & return_from_irq_instr_in;
      hwclr0  = (r.fsm == ST_ENTRY) & (r.step == r.last) & ~r.src1;
      hwclr1  = (r.fsm == ST_ENTRY) & (r.step == r.last) & r.src1;
      wr_flag = we_in & (addr_in == OFS_FLAG);
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      n           = r;
      n.stk       = '0;
      n.vec_valid = 1'b0;
      n.ret_done  = 1'b0;
      n.rdata     = 8'h00;

      // Two-stage synchroniser, edge logic reads the second stage only
      n.sync0 = {r.sync0[0], ext0_pin_in};
      n.sync1 = {r.sync1[0], ext1_pin_in};
      n.prev0 = r.sync0[1];
      n.prev1 = r.sync1[1];

      // Flags: a new event wins over any clear in the same cycle
      n.flag0 = ~lvl0 & (set0 | (r.flag0 & ~(hwclr0
                | (wr_flag & wdata_in[BIT_FLAG0]))));
      n.flag1 = ~lvl1 & (set1 | (r.flag1 & ~(hwclr1
                | (wr_flag & wdata_in[BIT_FLAG1]))));

      // Register writes
      if (we_in)
      begin
         case (addr_in)
            OFS_MASK:
            begin
               n.en1 = wdata_in[BIT_EN1];
               n.en0 = wdata_in[BIT_EN0];
            end
            OFS_CTRL:
            begin
               n.sense1 = wdata_in[BIT_S1_HI:BIT_S1_LO];
               n.sense0 = wdata_in[BIT_S0_HI:BIT_S0_LO];
            end
            OFS_STAT: n.gie = wdata_in[BIT_GIE];
            default:  n.gie = n.gie;
         endcase
      end

      // Register reads, data stands one cycle after the strobe
      if (re_in)
      begin
         case (addr_in)
            OFS_MASK: n.rdata = {r.en1, r.en0, 6'h00};
            OFS_FLAG: n.rdata = {r.flag1 & ~lvl1, r.flag0 & ~lvl0,
                                 6'h00};
            OFS_CTRL: n.rdata = {4'h0, r.sense1, r.sense0};
            OFS_STAT: n.rdata = {r.gie, 7'h00};
            default:  n.rdata = 8'h00;
         endcase
      end

      // Sequencer; only the enable bit is touched, no status copy kept
      case (r.fsm)
         ST_IDLE:
         begin
            if (accept)
            begin
               n.fsm   = ST_ENTRY;
               n.gie   = 1'b0;
               n.src1  = ~pend0;
               n.pc    = pc_in;
               n.step  = 4'h0;
               n.last  = sleep_in ? 4'(ENTRY_CYC + SLEEP_EXTRA - 4'h1)
                                  : 4'(ENTRY_CYC - 4'h1);
               n.ebusy = 1'b1;
               n.stk.push = 1'b1;
               n.stk.data = pc_in[7:0];
            end
            else if (ret_go)
            begin
               n.fsm      = ST_RETURN;
               n.step     = 4'h0;
               n.last     = 4'(RET_CYC - 4'h1);
               n.rbusy    = 1'b1;
               n.stk.pop  = 1'b1;
            end
         end
         ST_ENTRY:
         begin
            n.step = 4'(r.step + 4'h1);
            if (r.step == 4'h0)
            begin
               n.stk.push = 1'b1;
               n.stk.data = {3'h0, r.pc[PC_W-1:8]};
            end
            if (r.step == r.last)
            begin
               n.fsm       = ST_IDLE;
               n.ebusy     = 1'b0;
               n.vec_valid = 1'b1;
               n.vector    = r.src1 ? VEC_EXT1 : VEC_EXT0;
            end
         end
         ST_RETURN:
         begin
            n.step = 4'(r.step + 4'h1);
            if (r.step == 4'h0)
               n.stk.pop = 1'b1;
            if (r.step == r.last)
            begin
               // Back in idle, the next accept needs a fresh instr_done,
               // so one instruction of the old program always runs.
               n.fsm         = ST_IDLE;
               n.rbusy       = 1'b0;
               n.gie         = 1'b1;
               n.ret_done    = 1'b1;
               n.stk.sp_add2 = 1'b1;
            end
         end
         default: n.fsm = ST_IDLE;
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         r        <= '0;
         r.fsm    <= ST_IDLE;
         r.gie    <= GIE_RST;
         r.sense0 <= SENSE_RST;
         r.sense1 <= SENSE_RST;
         r.sync0  <= 2'h3;
         r.sync1  <= 2'h3;
         r.prev0  <= 1'b1;
         r.prev1  <= 1'b1;
      end
      else
         r <= n;
   end

   // ==========================================================
   // Outputs straight from the state register
   assign rdata_out      = r.rdata;
   assign gie_out        = r.gie;
   assign entry_busy_out = r.ebusy;
   assign ret_busy_out   = r.rbusy;
   assign vec_valid_out  = r.vec_valid;
   assign vector_out     = r.vector;
   assign ret_done_out   = r.ret_done;
   assign stack_out      = r.stk;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   a_entry_gie_clr: assert property (
      accept |=> !gie_out && entry_busy_out)
      else $error("global enable not cleared on accept");

   a_ret_gie_set: assert property (
      ret_go |=> ##4 gie_out && ret_done_out)
      else $error("return did not set global enable");

   a_vec_flag_clr: assert property (
      hwclr0 && !set0 |=> !r.flag0)
      else $error("flag not cleared on vectoring");

   a_w1c_keep: assert property (
      wr_flag && !wdata_in[BIT_FLAG0] && r.flag0 && !hwclr0 && !lvl0
      |=> r.flag0)
      else $error("writing zero changed a flag");

   a_flag_masked: assert property (
      set1 && !r.en1 |=> r.flag1 [*2])
      else $error("masked event lost its flag");

   a_entry_len: assert property (
      accept && !sleep_in |=> entry_busy_out [*4] ##1 vec_valid_out)
      else $error("entry length wrong");

   a_sleep_len: assert property (
      accept && sleep_in |=> entry_busy_out [*8] ##1 vec_valid_out)
      else $error("sleep entry length wrong");

   a_ret_len: assert property (
      ret_go |=> ret_busy_out [*4] ##1
      (!ret_busy_out && stack_out.sp_add2 && !stack_out.pop))
      else $error("return length wrong");

   a_prio_low: assert property (
      accept && pend0 && !sleep_in |=> ##4 vec_valid_out && vector_out == VEC_EXT0)
      else $error("lower vector not served first");

   a_level_rd: assert property (
      re_in && addr_in == OFS_FLAG && lvl0 |=> !rdata_out[BIT_FLAG0])
      else $error("level flag read as set");

   a_mask_rsvd: assert property (
      re_in && addr_in == OFS_MASK |=> rdata_out[5:0] == 6'h00)
      else $error("mask reserved bits nonzero");

   // ==========================================================
   // Stack, edge and decode checks
   // Edge checks read the sync stages directly, not the edge function,
   // so a broken decode in the function still shows up here.
   a_entry_push: assert property (
      accept |=> stack_out.push && stack_out.data == r.pc[7:0]
      ##1 stack_out.push && stack_out.data == {3'h0, r.pc[PC_W-1:8]})
      else $error("program counter push wrong");

   a_ret_pops: assert property (
      ret_go |=> stack_out.pop ##1 stack_out.pop ##1 !stack_out.pop && !stack_out.push)
      else $error("return pop sequence wrong");

   a_busy_excl: assert property (
      entry_busy_out |-> !ret_busy_out)
      else $error("entry and return overlap");

   a_fall_flag: assert property (
      r.sense1 == SENSE_FALL && r.prev1 && !r.sync1[1] |=> r.flag1)
      else $error("falling edge did not set flag");

   a_rise_flag: assert property (
      r.sense0 == SENSE_RISE && !r.prev0 && r.sync0[1] |=> r.flag0)
      else $error("rising edge did not set flag");

   a_any_edge: assert property (
      r.sense1 == SENSE_ANY && (r.prev1 != r.sync1[1]) |=> r.flag1)
      else $error("pin change did not set flag");

   a_level_noflag: assert property (
      r.sense0 == SENSE_LEVEL |=> !r.flag0)
      else $error("level request latched a flag");

   a_level_req: assert property (
      r.fsm == ST_IDLE && r.gie && instr_done_in && !return_from_irq_instr_in && r.en0
      && r.sense0 == SENSE_LEVEL && !r.sync0[1] |=> entry_busy_out)
      else $error("held level not served");

   a_gie_gate: assert property (
      r.fsm == ST_IDLE && !r.gie |=> !entry_busy_out)
      else $error("entry while global enable off");

   a_flag_rsvd: assert property (
      re_in && addr_in == OFS_FLAG |=> rdata_out[5:0] == 6'h00)
      else $error("flag reserved bits nonzero");

   a_ctrl_rd: assert property (
      re_in && addr_in == OFS_CTRL |=> rdata_out == {4'h0, r.sense1, r.sense0})
      else $error("sense bits misplaced");

   a_prio_pick: assert property (
      accept && !pend0 |=> r.src1)
      else $error("request 1 not chosen");

   a_vec_addr: assert property (
      vec_valid_out |-> vector_out == VEC_EXT0 || vector_out == VEC_EXT1)
      else $error("vector address unknown");

   a_w1c_clr: assert property (
      wr_flag && wdata_in[BIT_FLAG0] && !set0 |=> !r.flag0)
      else $error("writing one kept a flag");

endmodule : icx_ctrl

`default_nettype wire

// >>> icx_core_model.sv
`default_nettype none

module icx_core_model
   import icx_pkg::*;
(
   // Clock and reset
   input  wire logic            clock_in,
   input  wire logic            reset_in,
   // Controller status
   input  wire logic            busy_in,
   input  wire logic            vec_in,
   // Core requests
   output var  logic            instr_done_out,
   output var  logic            return_from_irq_instr_out,
   output var  logic [PC_W-1:0] pc_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [1:0] gap_r;
   logic [2:0] run_r;
   logic       inh_r;

   // ==========================================================
   // Core pacing
   // Four-cycle instructions, none while the controller is busy
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         gap_r          <= 2'h0;
         run_r          <= 3'h0;
         inh_r          <= 1'b0;
         instr_done_out <= 1'b0;
         return_from_irq_instr_out       <= 1'b0;
         pc_out         <= 13'h1A5C;
      end
      else
      begin
         instr_done_out <= 1'b0;
         return_from_irq_instr_out       <= 1'b0;
         if (!busy_in && !instr_done_out && !return_from_irq_instr_out)
         begin
            gap_r <= gap_r + 2'h1;
            if (gap_r == 2'h2)
            begin
               gap_r <= 2'h0;
               // Handler of four instructions ends in a return
               if (inh_r && run_r == 3'h4)
               begin
                  return_from_irq_instr_out <= 1'b1;
                  inh_r    <= 1'b0;
               end
               else
               begin
                  instr_done_out <= 1'b1;
                  pc_out         <= pc_out + 13'h0001;
                  run_r          <= run_r + 3'h1;
               end
            end
         end
         if (vec_in)
         begin
            inh_r <= 1'b1;
            run_r <= 3'h0;
         end
      end
   end

endmodule : icx_core_model

`default_nettype wire

// >>> test_interrupt_control_ext_pins.sv
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
$display("Error at %0t: got %h want %h", $time, g, e); end end

module test_interrupt_control_ext_pins
   import icx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock_in = 0, reset_in = 1, we_in = 0, re_in = 0, sleep_in = 0;
   logic ext0_pin_in = 1, ext1_pin_in = 1;
   logic [ICX_AW-1:0] addr_in = '0;
   logic [7:0] wdata_in = '0, rdata_out, e8, hi_exp;
   logic gie_out, entry_busy_out, ret_busy_out, vec_valid_out, ret_done_out;
   logic instr_done_in, return_from_irq_instr_in, rd_pend = 0, hi_pend = 0, seen = 0, busy_d = 0;
   logic [PC_W-1:0] vector_out, pc_in, pc_q, e13;
   icx_stack_t stack_out;
   int err_total = 0, tests_run = 0, exp_len = 4, ebc = 0, rbc = 0, pops = 0;
   logic [7:0] rq[$];
   logic [PC_W-1:0] vq[$];
   logic [31:0] rs = 32'h51b2108c;

   icx_ctrl i_icx_ctrl (.clock_in, .reset_in, .addr_in, .wdata_in, .we_in, .re_in,
      .rdata_out, .instr_done_in, .sleep_in, .return_from_irq_instr_in, .pc_in, .gie_out,
      .entry_busy_out, .ret_busy_out, .vec_valid_out, .vector_out, .ret_done_out,
      .stack_out, .ext0_pin_in, .ext1_pin_in);
   icx_core_model i_icx_core_model (.clock_in, .reset_in,
      .busy_in(entry_busy_out | ret_busy_out), .vec_in(vec_valid_out),
      .instr_done_out(instr_done_in), .return_from_irq_instr_out(return_from_irq_instr_in), .pc_out(pc_in));

   // ==========================================================
   // Clock, helpers and bus tasks
   initial
   begin
      forever #50 clock_in = ~clock_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in  <= a;
      wdata_in <= d;
      we_in    <= 1'b1;
      @(posedge clock_in);
      we_in <= 1'b0;
   endtask : wr

   // Read result is noted here and compared by the watcher
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clock_in);
      addr_in <= a;
      re_in   <= 1'b1;
      rq.push_back(e);
      @(posedge clock_in);
      re_in <= 1'b0;
   endtask : rd

   task automatic pin(input int n, input int len);
      @(posedge clock_in);
      if (n == 0) ext0_pin_in <= 1'b0;
      else ext1_pin_in <= 1'b0;
      repeat (len) @(posedge clock_in);
      ext0_pin_in <= 1'b1;
      ext1_pin_in <= 1'b1;
   endtask : pin

   // Bounded wait until every noted vector is served and returned from
   task automatic wait_idle();
      int n;
      n = 0;
      while ((vq.size() != 0 || gie_out !== 1'b1 || ret_busy_out) && n < 500)
      begin
         @(posedge clock_in);
         n++;
      end
      if (n == 500)
      begin
         err_total++;
         $display("Error at %0t: wait timed out", $time);
         stop_test();
      end
   endtask : wait_idle

   // ==========================================================
   // Watcher: registered samples, then compares off the edge
   always @(posedge clock_in)
   begin
      rd_pend <= re_in;
      pc_q    <= pc_in;
      seen    <= ret_done_out ? 1'b0 : (instr_done_in ? 1'b1 : seen);
   end

   always @(negedge clock_in)
   begin
      if (!reset_in)
      begin
         if (rd_pend)
         begin
            e8 = rq.pop_front();
            `CHK(rdata_out, e8)
         end
         if (vec_valid_out)
         begin
            e13 = (vq.size() != 0) ? vq.pop_front() : 13'h1FFF;
            `CHK(vector_out, e13)
            `CHK(gie_out, 1'b0)
         end
         if (entry_busy_out && !busy_d) `CHK(seen, 1'b1)
         if (entry_busy_out) ebc++;
         else if (ebc != 0)
         begin
            `CHK(ebc, exp_len)
            ebc = 0;
         end
         if (ret_busy_out) rbc++;
         else if (rbc != 0)
         begin
            `CHK(rbc, 4)
            rbc = 0;
         end
         if (stack_out.pop) pops++;
         if (ret_done_out)
         begin
            `CHK(gie_out, 1'b1)
            `CHK(stack_out.sp_add2 && pops == 2, 1'b1)
            pops = 0;
         end
         if (stack_out.push)
         begin
            e8 = hi_pend ? hi_exp : pc_q[7:0];
            `CHK(stack_out.data, e8)
            hi_exp = {3'h0, pc_q[12:8]};
            hi_pend = !hi_pend;
         end
         busy_d = entry_busy_out;
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clock_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
      repeat (4)
      begin
         rs = xs(rs);
         wr(OFS_MASK, rs[7:0]);
         rd(OFS_MASK, rs[7:0] & 8'hC0);
      end
      wr(OFS_MASK, 8'h00);
      wr(OFS_FLAG, 8'h3F);
      rd(OFS_FLAG, 8'h00);
      ext0_pin_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      rd(OFS_FLAG, 8'h00);
      ext0_pin_in <= 1'b1;
      $display("Test registers done");
      // Request 1 on falling edge, request 0 on rising edge
      wr(OFS_CTRL, 8'h0B);
      pin(0, 3);
      pin(1, 3);
      repeat (5) @(posedge clock_in);
      rd(OFS_FLAG, 8'hC0);
      wr(OFS_FLAG, 8'h00);
      rd(OFS_FLAG, 8'hC0);
      wr(OFS_FLAG, 8'h40);
      rd(OFS_FLAG, 8'h80);
      pin(0, 3);
      wr(OFS_MASK, 8'hC0);
      repeat (10) @(posedge clock_in);
      rd(OFS_FLAG, 8'hC0);
      vq.push_back(VEC_EXT0);
      vq.push_back(VEC_EXT1);
      wr(OFS_STAT, 8'h80);
      wait_idle();
      rd(OFS_FLAG, 8'h00);
      $display("Test priority done");
      // Any edge on request 1, taken while asleep
      wr(OFS_CTRL, 8'h07);
      sleep_in <= 1'b1;
      exp_len = 8;
      vq.push_back(VEC_EXT1);
      pin(1, 3);
      wait_idle();
      sleep_in <= 1'b0;
      exp_len = 4;
      $display("Test sleep done");
      // Level request dropped while global enable is off
      wr(OFS_CTRL, 8'h00);
      wr(OFS_STAT, 8'h00);
      pin(0, 6);
      repeat (20) @(posedge clock_in);
      wr(OFS_STAT, 8'h80);
      repeat (30) @(posedge clock_in);
      // Held level keeps requesting, one vector per return
      vq.push_back(VEC_EXT0);
      vq.push_back(VEC_EXT0);
      ext0_pin_in <= 1'b0;
      for (int k = 0; k < 300 && vq.size() != 0; k++) @(posedge clock_in);
      ext0_pin_in <= 1'b1;
      wait_idle();
      repeat (30) @(posedge clock_in);
      $display("Test level done");
      stop_test();
   end

endmodule : test_interrupt_control_ext_pins

`default_nettype wire
